/* logic/ctm_timer.v */
// Compact timer: counter, comparators, match flags and output pin logic
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ctm_consts.vh"

module ctm_timer #(
  parameter CNT_W = 10
) (
  input  wire                    clk,
  input  wire                    nrst,
  input  wire                    tick_in,
  input  wire [`CTM_ADDR_W-1:0]  reg_addr,
  input  wire [CNT_W-1:0]        reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [CNT_W-1:0]        reg_rdata,
  output reg                     pin_out,
  output wire                    pin_oe,
  output wire                    match_a_flag,
  output wire                    match_p_flag
);

  // ----------------------------------------------------------------
  // Tick input synchroniser (timer clock from outside)
  // ----------------------------------------------------------------
  reg        tick_s1_reg;
  reg        tick_s2_reg;
  reg        tick_s3_reg;
  wire       tick_en;

  always @(posedge clk) begin
    if (!nrst) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
    end else begin
      tick_s1_reg <= tick_in;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
    end
  end

  assign tick_en = tick_s2_reg & ~tick_s3_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]       ctrl0_reg;
  reg  [7:0]       ctrl1_reg;
  reg  [CNT_W-1:0] cmpa_reg;
  reg  [CNT_W-1:0] count_reg;
  reg  [CNT_W-1:0] count_next;
  reg              flag_a_reg;
  reg              flag_p_reg;
  reg              on_d_reg;
  reg              pwm_reg;
  reg              pwm_next;
  reg              pin_next;

  wire             counter_on     = ctrl0_reg[`CTM_C0_ON];
  wire [2:0]       period_bits    = ctrl0_reg[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
  wire [1:0]       mode_select    = ctrl1_reg[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0]       pin_action     = ctrl1_reg[`CTM_C1_PIN_HI:`CTM_C1_PIN_LO];
  wire             init_level     = ctrl1_reg[`CTM_C1_INIT];
  wire             output_invert  = ctrl1_reg[`CTM_C1_INV];
  wire             period_swap    = ctrl1_reg[`CTM_C1_SWAP];
  wire             clear_sel      = ctrl1_reg[`CTM_C1_CLRSEL];
  wire             on_rise        = counter_on & ~on_d_reg;

  wire             is_pwm  = (mode_select == `CTM_MODE_PWM);
  wire             is_cmp  = (mode_select == `CTM_MODE_CMP);
  wire             is_tmr  = (mode_select == `CTM_MODE_TMR);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Strobe aimed at one register offset
  function reg_hit(input                   strobe,
                   input [`CTM_ADDR_W-1:0] addr,
                   input [`CTM_ADDR_W-1:0] offset);
    reg_hit = strobe && (addr == offset);
  endfunction

  // Length in timer clocks; a zero setting stands for the full range
  function [CNT_W:0] span_of(input [CNT_W-1:0] value);
    if (value == {CNT_W{1'b0}})
      span_of = {1'b1, {CNT_W{1'b0}}};
    else
      span_of = {1'b0, value};
  endfunction

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Matches judged on the next count, so a clear keeps the period exact
  wire [CNT_W-1:0] count_inc = count_reg + `CTM_CNT_ONE;
  // Period bits match the top three counter bits, with the lower seven at zero
  wire       p_hit    = (period_bits != `CTM_PER_ZERO) &&
                        (count_inc[CNT_W-1:CNT_W-3] == period_bits) &&
                        (count_inc[CNT_W-4:0] == {(CNT_W-3){1'b0}});
  wire       ovf_hit  = (count_reg == `CTM_CNT_MAX);
  wire       p_match  = p_hit | ((period_bits == `CTM_PER_ZERO) & ovf_hit);
  wire       a_match  = (cmpa_reg != `CTM_CMPA_RST) && (count_inc == cmpa_reg);
  wire       run      = counter_on & tick_en;

  // Period and duty in clocks for PWM; a zero setting means 1024
  wire [CNT_W:0] p_len  = span_of({period_bits, {`CTM_PER_SHIFT{1'b0}}});
  wire [CNT_W:0] a_len  = span_of(cmpa_reg);
  wire [CNT_W:0] period = period_swap ? a_len : p_len;
  wire [CNT_W:0] duty   = period_swap ? p_len : a_len;
  wire           full   = (duty >= period);

  reg        clear_now;
  reg        set_a;
  reg        set_p;

  always @* begin
    set_a = 1'b0;
    set_p = 1'b0;
    if (is_pwm) begin
      // Clear select ignored; the period comparator, or compare A when swapped, restarts the cycle
      clear_now = period_swap ? (a_match | (ovf_hit & (cmpa_reg == `CTM_CMPA_RST)))
                              : p_match;
      set_a = a_match;
      set_p = p_match;
    end else if (clear_sel) begin
      clear_now = a_match | ovf_hit;
      set_a = a_match;
    end else begin
      clear_now = p_match;
      set_a = a_match;
      set_p = p_match;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @* begin
    count_next = count_reg;
    if (on_rise)
      count_next = `CTM_CNT_ZERO;
    else if (run)
      count_next = clear_now ? `CTM_CNT_ZERO : count_inc;
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always @* begin
    pwm_next = pwm_reg;
    if (on_rise)
      pwm_next = 1'b1;
    else if (run) begin
      if (clear_now)
        pwm_next = 1'b1;
      else if (!full && ({1'b0, count_inc} >= duty))
        pwm_next = 1'b0;
    end
  end

  always @* begin
    pin_next = pin_out;
    if (is_pwm) begin
      case (pin_action)
        `CTM_PWM_INACT: pin_next = ~init_level;
        `CTM_PWM_ACT:   pin_next = init_level;
        `CTM_PWM_WAVE:  pin_next = pwm_next ? init_level : ~init_level;
        default:        pin_next = ~init_level;
      endcase
      pin_next = pin_next ^ output_invert;
    end else if (is_cmp) begin
      if (on_rise)
        pin_next = init_level;
      else if (run && set_a) begin
        case (pin_action)
          `CTM_PIN_NONE:   pin_next = pin_out;
          `CTM_PIN_LOW:    pin_next = 1'b0;
          `CTM_PIN_HIGH:   pin_next = 1'b1;
          `CTM_PIN_TOGGLE: pin_next = ~pin_out;
          default:         pin_next = pin_out;
        endcase
      end
    end
  end

  assign pin_oe = is_cmp | is_pwm;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire wr_ctrl0 = reg_hit(reg_wr, reg_addr, `CTM_OFF_CTRL0);
  wire wr_ctrl1 = reg_hit(reg_wr, reg_addr, `CTM_OFF_CTRL1);
  wire wr_cmpa  = reg_hit(reg_wr, reg_addr, `CTM_OFF_CMPA);
  wire wr_flags = reg_hit(reg_wr, reg_addr, `CTM_OFF_FLAGS);

  always @(posedge clk) begin
    if (!nrst) begin
      ctrl0_reg <= `CTM_CTRL_RST;
      ctrl1_reg <= `CTM_CTRL_RST;
      cmpa_reg  <= `CTM_CMPA_RST;
    end else begin
      if (wr_ctrl0)
        ctrl0_reg <= reg_wdata[`CTM_CTRL_W-1:0];
      if (wr_ctrl1)
        ctrl1_reg <= reg_wdata[`CTM_CTRL_W-1:0];
      if (wr_cmpa)
        cmpa_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Counter, waveform and pin state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      on_d_reg  <= 1'b0;
      count_reg <= `CTM_CNT_ZERO;
      pwm_reg   <= 1'b0;
      pin_out   <= 1'b0;
    end else begin
      on_d_reg  <= counter_on;
      count_reg <= count_next;
      pwm_reg   <= pwm_next;
      pin_out   <= pin_next;
    end
  end

  // ----------------------------------------------------------------
  // Match flags, cleared by writing one
  // ----------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      flag_a_reg <= (run & set_a) |
                    (flag_a_reg & ~(wr_flags & reg_wdata[`CTM_FL_A]));
      flag_p_reg <= (run & set_p) |
                    (flag_p_reg & ~(wr_flags & reg_wdata[`CTM_FL_P]));
    end
  end

  // ----------------------------------------------------------------
  // Read data, standing only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= {CNT_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `CTM_OFF_CTRL0: reg_rdata <= {{(CNT_W-`CTM_CTRL_W){1'b0}}, ctrl0_reg};
        `CTM_OFF_CTRL1: reg_rdata <= {{(CNT_W-`CTM_CTRL_W){1'b0}}, ctrl1_reg};
        `CTM_OFF_CMPA:  reg_rdata <= cmpa_reg;
        `CTM_OFF_COUNT: reg_rdata <= count_reg;
        `CTM_OFF_FLAGS: reg_rdata <= {{(CNT_W-2){1'b0}}, flag_p_reg, flag_a_reg};
        default:        reg_rdata <= {CNT_W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {CNT_W{1'b0}};
    end
  end

  assign match_a_flag = flag_a_reg;
  assign match_p_flag = flag_p_reg;

endmodule

/* inc/ctm_consts.vh */
// Constants for the compact timer mode logic
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH

// ------------------------------------------------------------------
// Register map (word offsets on the plain register port)
// ------------------------------------------------------------------
`define CTM_ADDR_W        3
`define CTM_OFF_CTRL0     3'h0
`define CTM_OFF_CTRL1     3'h1
`define CTM_OFF_CMPA      3'h2
`define CTM_OFF_COUNT     3'h3
`define CTM_OFF_FLAGS     3'h4

// ------------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------------
// ctrl0: [3] counter_on, [2:0] period_compare_bits
`define CTM_C0_ON         3
`define CTM_C0_PER_HI     2
`define CTM_C0_PER_LO     0
// ctrl1 (timer_control_one)
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_PIN_HI     5
`define CTM_C1_PIN_LO     4
`define CTM_C1_INIT       3
`define CTM_C1_INV        2
`define CTM_C1_SWAP       1
`define CTM_C1_CLRSEL     0
// flags: [0] match_a_flag, [1] match_p_flag (write 1 to clear)
`define CTM_FL_A          0
`define CTM_FL_P          1

// ------------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------------
`define CTM_CTRL_RST      8'h00
`define CTM_CTRL_W        8
`define CTM_CMPA_RST      10'h000
`define CTM_CNT_ZERO      10'h000
`define CTM_CNT_MAX       10'h3ff
`define CTM_CNT_ONE       10'h001
`define CTM_PER_ZERO      3'h0
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3
`define CTM_PIN_NONE      2'h0
`define CTM_PIN_LOW       2'h1
`define CTM_PIN_HIGH      2'h2
`define CTM_PIN_TOGGLE    2'h3
`define CTM_PWM_INACT     2'h0
`define CTM_PWM_ACT       2'h1
`define CTM_PWM_WAVE      2'h2
`define CTM_PER_SHIFT     7

`endif

/* verification/ctm_timer_asserts.sv */
// Port-level assertions for the compact timer
`timescale 1ns/1ps
`include "ctm_consts.vh"
module ctm_timer_asserts #(
  parameter CNT_W = 10
) (
  input wire                   clk,
  input wire                   nrst,
  input wire                   tick_in,
  input wire [`CTM_ADDR_W-1:0] reg_addr,
  input wire [CNT_W-1:0]       reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [CNT_W-1:0]       reg_rdata,
  input wire                   pin_out,
  input wire                   pin_oe,
  input wire                   match_a_flag,
  input wire                   match_p_flag
);
  // ------
  // Shadow of the control fields
  // ------
  reg  [7:0]       c1_reg;
  reg              on_reg;
  reg  [2:0]       per_reg;
  reg  [CNT_W-1:0] cmpa_reg;
  reg  [1:0]       hist_reg;
  wire [1:0]       mode = c1_reg[7:6];
  wire             pwm = (mode == `CTM_MODE_PWM);
  wire             quiet = on_reg && (hist_reg == 2'h0);
  wire [CNT_W:0]   period = (per_reg == 3'h0) ? 11'h400 : {1'b0, per_reg, 7'h00};
  always @(posedge clk) begin
    if (!nrst) begin
      c1_reg <= 8'h00;
      on_reg <= 1'b0;
      per_reg <= 3'h0;
      cmpa_reg <= {CNT_W{1'b0}};
      hist_reg <= 2'h0;
    end else begin
      hist_reg <= {hist_reg[0], reg_wr};
      if (reg_wr && reg_addr == `CTM_OFF_CTRL0) begin
        on_reg <= reg_wdata[3];
        per_reg <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `CTM_OFF_CTRL1) c1_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `CTM_OFF_CMPA) cmpa_reg <= reg_wdata;
    end
  end
  // ------
  // Properties
  // ------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside read slot");
  chk_pin_enable: assert property (pin_oe == (mode == `CTM_MODE_CMP || pwm))
    else $error("pin enable wrong for mode");
  chk_p_blocked: assert property (c1_reg[0] && !pwm && !match_p_flag |=> !match_p_flag)
    else $error("period flag set with clear on A");
  chk_a_sticky: assert property (match_a_flag && !(reg_wr && reg_addr == `CTM_OFF_FLAGS
    && reg_wdata[0]) |=> match_a_flag)
    else $error("flag A dropped");
  chk_start_level: assert property ($rose(on_reg) && mode == `CTM_MODE_CMP
    |-> ##[1:2] pin_out == c1_reg[3]) else $error("pin not at initial level");
  chk_pwm_forced: assert property (pwm && !c1_reg[5] && quiet
    |-> pin_out == ((c1_reg[4] ~^ c1_reg[3]) ^ c1_reg[2])) else $error("forced pin wrong");
  chk_full_duty: assert property (pwm && c1_reg[5:4] == `CTM_PWM_WAVE && !c1_reg[1]
    && quiet && {1'b0, cmpa_reg} >= period |-> pin_out == (c1_reg[3] ^ c1_reg[2]))
    else $error("full duty pin not active");
  chk_a_zero: assert property (!pwm && cmpa_reg == 0 && !match_a_flag |=> !match_a_flag)
    else $error("flag A set with compare zero");
  cover property ($rose(match_a_flag));
  cover property ($rose(match_p_flag));
  cover property (pwm && $fell(pin_out));
endmodule

bind ctm_timer ctm_timer_asserts #(.CNT_W(CNT_W)) i_chk (.clk(clk), .nrst(nrst),
  .tick_in(tick_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

/* verification/ctm_timer_test.sv */
// Self-checking testbench for the compact timer
`timescale 1ns/1ps
`include "ctm_consts.vh"
module ctm_timer_test;
  reg        clk = 1'b0, nrst = 1'b0, tick_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [2:0] reg_addr = 3'h0;
  reg  [9:0] reg_wdata = 10'h000, rv = 10'h000;
  reg  [7:0] rs = 8'h44;
  wire [9:0] reg_rdata;
  wire       pin_out, pin_oe, match_a_flag, match_p_flag;
  integer    fail_count = 0, total_checks = 0, i;
  ctm_timer #(.CNT_W(10)) i_dut (.clk(clk), .nrst(nrst), .tick_in(tick_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
  always #2.5 clk = ~clk;
  // ------
  // Helpers
  // ------
  function [7:0] lf(input [7:0] x);
    lf = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function pe(input [1:0] act, input on, input ini, input inv);
    pe = ((act == `CTM_PWM_ACT || (act == `CTM_PWM_WAVE && on)) ? ini : ~ini) ^ inv;
  endfunction
  task chk(input [9:0] s, input [9:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h, expected %h", $time, s, e);
    end
  endtask
  task wr(input [2:0] a, input [9:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task tk(input integer n);
    repeat (n) begin
      @(posedge clk);
      tick_in <= 1'b1;
      repeat (2) @(posedge clk);
      tick_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    #1;
  endtask
  task run_cmp(input [1:0] md, input [1:0] act, input cs, input [9:0] a);
    reg ini, ep;
    ini = ~act[1];
    ep = (act == `CTM_PIN_NONE) ? ini : (act == `CTM_PIN_TOGGLE) ? ~ini : act[1];
    wr(0, 0);
    wr(1, {2'b00, md, act, ini, 2'b00, cs});
    wr(2, a);
    wr(4, 3);
    wr(0, 9);
    rd(3);
    chk(rv, 0);
    if (md == `CTM_MODE_CMP) chk(pin_out, ini);
    tk(a - 1);
    chk(match_a_flag, 0);
    tk(1);
    chk(match_a_flag, 1);
    chk(pin_oe, md == `CTM_MODE_CMP);
    if (md == `CTM_MODE_CMP) chk(pin_out, ep);
    if (!cs) tk(128 - a);
    chk(match_p_flag, !cs);
    if (md == `CTM_MODE_CMP) chk(pin_out, ep);
    rd(3);
    chk(rv, 0);
    $display("compare test done, mode %h action %h", md, act);
  endtask
  task run_pwm(input sw, input inv, input [1:0] act, input ini, input [9:0] a);
    integer pd, dt, n1, n2;
    pd = sw ? a : 128;
    dt = sw ? 128 : a;
    n1 = (dt < pd ? dt : pd) / 2;
    n2 = dt < pd ? (dt + pd) / 2 : pd - 1;
    wr(0, 0);
    wr(1, {2'b00, `CTM_MODE_PWM, act, ini, inv, sw, 1'b1});
    wr(2, a);
    wr(4, 3);
    wr(0, 9);
    tk(n1);
    chk(pin_out, pe(act, 1, ini, inv));
    tk(n2 - n1);
    chk(pin_out, pe(act, dt >= pd, ini, inv));
    tk(pd - n2);
    chk(match_p_flag, 1);
    chk(match_a_flag, sw || dt < pd);
    chk(pin_out, pe(act, 1, ini, inv));
    rd(3);
    chk(rv, 0);
    $display("pwm test done, swap %h action %h", sw, act);
  endtask
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    #400000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i);
      chk(rv, 0);
    end
    chk(pin_oe, 1);
    wr(7, 10'h3ff);
    wr(1, 10'h3ff);
    rd(1);
    chk(rv, 10'h0ff);
    chk(pin_oe, 0);
    wr(1, 10'h040);
    rd(7);
    chk(rv, 0);
    chk(pin_oe, 0);
    $display("register test done");
    for (i = 0; i < 4; i = i + 1) begin
      rs = lf(rs);
      run_cmp(`CTM_MODE_CMP, i[1:0], 0, rs[5:0] + 10'h001);
    end
    rs = lf(rs);
    run_cmp(`CTM_MODE_CMP, `CTM_PIN_TOGGLE, 1, {2'b00, rs} + 10'h082);
    run_cmp(`CTM_MODE_TMR, `CTM_PIN_TOGGLE, 1, rs[5:0] + 10'h001);
    wr(0, 0);
    wr(1, 1);
    wr(2, 0);
    wr(4, 3);
    wr(0, 8);
    tk(1023);
    rd(3);
    chk(rv, 10'h3ff);
    chk(match_a_flag, 0);
    tk(2);
    rd(3);
    chk(rv, 10'h001);
    chk(match_p_flag, 0);
    wr(0, 0);
    tk(2);
    rd(3);
    chk(rv, 10'h001);
    $display("overflow test done");
    rs = lf(rs);
    run_pwm(0, 0, `CTM_PWM_WAVE, 1, rs[5:0] + 10'h010);
    run_pwm(1, 1, `CTM_PWM_WAVE, 0, 200);
    run_pwm(0, 1, `CTM_PWM_WAVE, 1, 300);
    run_pwm(0, 0, `CTM_PWM_INACT, 1, 32);
    run_pwm(0, 1, `CTM_PWM_ACT, 0, 32);
    tally_and_finish;
  end
endmodule
